// ### hw/dvpm_pkg.sv
// Constants for the DS1/VT path performance monitor.
// Assumes a single 100 MHz clock and a one-second tick from the card.
package dvpm_pkg;
	localparam int CNT_W = 32;
	localparam int SEC_ERR_W = 16;
	localparam logic [15:0] PATH_ESF_SES_LIMIT = 16'h0140;
	localparam logic [15:0] PATH_SF_SES_LIMIT = 16'h0004;
	localparam logic [15:0] VT_SES_LIMIT = 16'h0258;
	localparam logic [3:0] UNAVAIL_RUN = 4'ha;
	localparam logic [1:0] VT_MAX_BIP_PER_SF = 2'h2;
	localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;
	typedef enum logic [1:0] {
		DVPM_AVAIL = 2'b00,
		DVPM_UNAVAIL = 2'b01
	} dvpm_avail_type;
endpackage

// ### hw/dvpm_unavail.sv
// Unavailable-state tracker for one monitored path.
// Assumes sec_i is a one-cycle pulse at each second boundary with ses_i valid.
`timescale 1ns/1ps
module dvpm_unavail
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Second result
	input wire logic sec_i,
	input wire logic ses_i,
	// Unavailable seconds to add at this boundary
	output logic [4:0] uas_add_o,
	output logic unavail_o
);
	dvpm_pkg::dvpm_avail_type state_r, state_nxt;
	// Run of like seconds; while unavailable it holds clean seconds not yet counted
	logic [3:0] run_r, run_nxt;

	always_comb
	begin
		state_nxt = state_r;
		run_nxt = run_r;
		uas_add_o = 5'h00;
		if (sec_i)
		begin
			unique case (state_r)
				dvpm_pkg::DVPM_AVAIL:
				begin
					run_nxt = ses_i ? run_r + 4'h1 : 4'h0;
					if (ses_i && run_nxt == dvpm_pkg::UNAVAIL_RUN)
					begin
						// Onset of the run counts too, so all ten are added
						state_nxt = dvpm_pkg::DVPM_UNAVAIL;
						uas_add_o = {1'b0, dvpm_pkg::UNAVAIL_RUN};
						run_nxt = 4'h0;
					end
				end
				dvpm_pkg::DVPM_UNAVAIL:
				begin
					// Clean seconds held until known not to end the period
					if (ses_i)
					begin
						uas_add_o = {1'b0, run_r} + 5'h01;
						run_nxt = 4'h0;
					end
					else
					begin
						run_nxt = run_r + 4'h1;
						if (run_nxt == dvpm_pkg::UNAVAIL_RUN)
						begin
							state_nxt = dvpm_pkg::DVPM_AVAIL;
							run_nxt = 4'h0;
						end
					end
				end
				default:
				begin
					state_nxt = dvpm_pkg::DVPM_AVAIL;
					run_nxt = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_r <= dvpm_pkg::DVPM_AVAIL;
			run_r <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			run_r <= run_nxt;
		end
	end

	assign unavail_o = (state_r == dvpm_pkg::DVPM_UNAVAIL);
endmodule

// ### hw/dvpm_monitor.sv
// DS1 transmit path and VT path performance monitor counters.
// Assumes one-cycle event pulses and defect levels synchronous to ref_clk_i.
// Operation
// (RULE1) Count seconds holding an alarm defect
// (RULE2) ESF: count each CRC-6 error as violation
// (RULE3) SF: count each framing bit error instead
// (RULE4) ESF errored: CRC, frame change, defect
// (RULE5) SF errored: framing bit, change, defect
// (RULE6) Count severe framing or alarm seconds separately
// (RULE7) ESF severe: 320 CRC errors or defect
// (RULE8) SF severe: four framing errors or defect
// (RULE9) Ten severe seconds enter unavailable; count them
// (RULE10) Ten clean exit seconds not counted unavailable
// (RULE11) No programmable thresholds on path counters
// (RULE12) VT parity: up to two per superframe
// (RULE13) VT errored second: parity error or defect
// (RULE14) VT severe: 600 parity errors or defect
// (RULE15) VT unavailable after ten severe seconds
// (RULE16) Evaluate and clear accumulations each second
`timescale 1ns/1ps
module dvpm_monitor
#(
	parameter int CNT_W = dvpm_pkg::CNT_W
)
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Interval tick and format
	input wire logic sec_tick_i,
	input wire logic path_esf_i,
	// DS1 transmit path anomalies and defects
	input wire logic crc_error_i,
	input wire logic framing_bit_error_i,
	input wire logic frame_change_i,
	input wire logic severe_framing_defect_i,
	input wire logic path_alarm_defect_i,
	// VT path anomalies and defects
	input wire logic [1:0] vt_bip_count_i,
	input wire logic vt_bip_valid_i,
	input wire logic vt_alarm_defect_i,
	input wire logic vt_pointer_loss_defect_i,
	input wire logic lower_layer_defect_i,
	// DS1 transmit path counters
	output logic [CNT_W-1:0] path_alarm_seconds_o,
	output logic [CNT_W-1:0] path_coding_violations_o,
	output logic [CNT_W-1:0] path_errored_seconds_o,
	output logic [CNT_W-1:0] path_frame_alarm_seconds_o,
	output logic [CNT_W-1:0] path_severe_seconds_o,
	output logic [CNT_W-1:0] path_unavailable_seconds_o,
	output logic path_unavailable_o,
	// VT path counters
	output logic [CNT_W-1:0] vt_coding_violations_o,
	output logic [CNT_W-1:0] vt_errored_seconds_o,
	output logic [CNT_W-1:0] vt_severe_seconds_o,
	output logic [CNT_W-1:0] vt_unavailable_seconds_o,
	output logic vt_unavailable_o,
	// Boundary strobe, counters just updated
	output logic sec_done_o
);
	// Per-second tallies need far fewer bits than the running counters
	localparam int SW = dvpm_pkg::SEC_ERR_W;

	// Per-second accumulations
	logic [SW-1:0] p_err_r, p_err_nxt;
	logic p_anom_r, p_anom_nxt;
	logic p_defect_r, p_defect_nxt;
	logic p_alarm_r, p_alarm_nxt;
	logic [SW-1:0] v_err_r, v_err_nxt;
	logic v_defect_r, v_defect_nxt;

	// Running counters
	logic [CNT_W-1:0] p_ais_r, p_ais_nxt;
	logic [CNT_W-1:0] p_cv_r, p_cv_nxt;
	logic [CNT_W-1:0] p_es_r, p_es_nxt;
	logic [CNT_W-1:0] p_sas_r, p_sas_nxt;
	logic [CNT_W-1:0] p_ses_r, p_ses_nxt;
	logic [CNT_W-1:0] p_uas_r, p_uas_nxt;
	logic [CNT_W-1:0] v_cv_r, v_cv_nxt;
	logic [CNT_W-1:0] v_es_r, v_es_nxt;
	logic [CNT_W-1:0] v_ses_r, v_ses_nxt;
	logic [CNT_W-1:0] v_uas_r, v_uas_nxt;
	logic done_r, done_nxt;

	logic p_anom_now;
	logic [1:0] v_bip_now;
	logic p_defect_now;
	logic v_defect_now;
	logic [SW-1:0] p_err_sec;
	logic [SW-1:0] v_err_sec;
	logic p_alarm_sec;
	logic p_defect_sec;
	logic v_defect_sec;
	logic p_es_sec, p_ses_sec, v_es_sec, v_ses_sec;
	logic [4:0] p_uas_add, v_uas_add;
	logic [SW-1:0] p_limit;
	logic [SW:0] p_err_sum;
	logic [SW:0] v_err_sum;

	// Anomaly source depends on superframe format
	assign p_anom_now = path_esf_i ? crc_error_i : framing_bit_error_i; // RULE2 RULE3
	// More than two per superframe cannot occur; clamp guards bad input
	assign v_bip_now = !vt_bip_valid_i ? 2'h0 :
		(vt_bip_count_i > dvpm_pkg::VT_MAX_BIP_PER_SF) ? dvpm_pkg::VT_MAX_BIP_PER_SF :
		vt_bip_count_i; // RULE12
	// Either framing or alarm defect marks a frame/alarm second
	assign p_defect_now = severe_framing_defect_i | path_alarm_defect_i;
	assign v_defect_now = vt_alarm_defect_i | vt_pointer_loss_defect_i | lower_layer_defect_i;

	// Events landing on the boundary cycle belong to the closing second
	// Carry bit pins the sum at full scale, so a storm cannot wrap below a limit
	assign p_err_sum = {1'b0, p_err_r} + {{SW{1'b0}}, p_anom_now};
	assign v_err_sum = {1'b0, v_err_r} + {{(SW-1){1'b0}}, v_bip_now};
	assign p_err_sec = p_err_sum[SW] ? '1 : p_err_sum[SW-1:0];
	assign v_err_sec = v_err_sum[SW] ? '1 : v_err_sum[SW-1:0];
	assign p_alarm_sec = p_alarm_r | path_alarm_defect_i;
	assign p_defect_sec = p_defect_r | p_defect_now;
	assign v_defect_sec = v_defect_r | v_defect_now;

	// Fixed limits only, no user threshold
	assign p_limit = path_esf_i ? dvpm_pkg::PATH_ESF_SES_LIMIT :
		dvpm_pkg::PATH_SF_SES_LIMIT; // RULE11
	// Change of frame only makes a second errored, never severe
	assign p_es_sec = (p_err_sec != '0) | p_anom_r | frame_change_i | p_defect_sec; // RULE4 RULE5
	assign p_ses_sec = (p_err_sec >= p_limit) | p_defect_sec; // RULE7 RULE8
	// VT defects mark both the errored and the severe second
	assign v_es_sec = (v_err_sec != '0) | v_defect_sec; // RULE13
	assign v_ses_sec = (v_err_sec >= dvpm_pkg::VT_SES_LIMIT) | v_defect_sec; // RULE14

	// Both trackers see the same boundary; each judges its own path
	dvpm_unavail u_path_unavail
	(
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.sec_i(sec_tick_i),
		.ses_i(p_ses_sec),
		.uas_add_o(p_uas_add),
		.unavail_o(path_unavailable_o)
	); // RULE9 RULE10

	dvpm_unavail u_vt_unavail
	(
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.sec_i(sec_tick_i),
		.ses_i(v_ses_sec),
		.uas_add_o(v_uas_add),
		.unavail_o(vt_unavailable_o)
	); // RULE15

	// Per-second accumulations and boundary strobe
	always_comb
	begin
		p_err_nxt = p_err_r;
		p_anom_nxt = p_anom_r;
		p_defect_nxt = p_defect_r;
		p_alarm_nxt = p_alarm_r;
		v_err_nxt = v_err_r;
		v_defect_nxt = v_defect_r;
		done_nxt = 1'b0;
		if (sec_tick_i)
		begin
			// Closing second is judged from the sec terms, then cleared
			p_err_nxt = '0; // RULE16
			p_anom_nxt = 1'b0;
			p_defect_nxt = 1'b0;
			p_alarm_nxt = 1'b0;
			v_err_nxt = '0;
			v_defect_nxt = 1'b0;
			done_nxt = 1'b1;
		end
		else
		begin
			p_err_nxt = p_err_sec;
			v_err_nxt = v_err_sec;
			p_anom_nxt = p_anom_r | frame_change_i;
			p_defect_nxt = p_defect_sec;
			p_alarm_nxt = p_alarm_sec;
			v_defect_nxt = v_defect_sec;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			p_err_r <= '0;
			p_anom_r <= 1'b0;
			p_defect_r <= 1'b0;
			p_alarm_r <= 1'b0;
			v_err_r <= '0;
			v_defect_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			p_err_r <= p_err_nxt;
			p_anom_r <= p_anom_nxt;
			p_defect_r <= p_defect_nxt;
			p_alarm_r <= p_alarm_nxt;
			v_err_r <= v_err_nxt;
			v_defect_r <= v_defect_nxt;
			done_r <= done_nxt;
		end
	end

	// DS1 transmit path counters; no programmable threshold is applied to any of them
	always_comb
	begin
		p_ais_nxt = p_ais_r;
		p_es_nxt = p_es_r;
		p_sas_nxt = p_sas_r;
		p_ses_nxt = p_ses_r;
		p_uas_nxt = p_uas_r;
		// Violations count live, each event once; counters wrap like the seconds
		p_cv_nxt = p_cv_r + (p_anom_now ? dvpm_pkg::CNT_ONE[CNT_W-1:0] :
			dvpm_pkg::CNT_ZERO[CNT_W-1:0]); // RULE2 RULE3
		if (sec_tick_i)
		begin
			if (p_alarm_sec)
				p_ais_nxt = p_ais_r + dvpm_pkg::CNT_ONE[CNT_W-1:0]; // RULE1
			if (p_es_sec)
				p_es_nxt = p_es_r + dvpm_pkg::CNT_ONE[CNT_W-1:0]; // RULE4 RULE5
			if (p_defect_sec)
				p_sas_nxt = p_sas_r + dvpm_pkg::CNT_ONE[CNT_W-1:0]; // RULE6
			if (p_ses_sec)
				p_ses_nxt = p_ses_r + dvpm_pkg::CNT_ONE[CNT_W-1:0]; // RULE7 RULE8
			// Tracker hands over whole held runs, up to ten at once
			p_uas_nxt = p_uas_r + {{(CNT_W-5){1'b0}}, p_uas_add}; // RULE9 RULE10
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			p_ais_r <= '0;
			p_cv_r <= '0;
			p_es_r <= '0;
			p_sas_r <= '0;
			p_ses_r <= '0;
			p_uas_r <= '0;
		end
		else
		begin
			p_ais_r <= p_ais_nxt;
			p_cv_r <= p_cv_nxt;
			p_es_r <= p_es_nxt;
			p_sas_r <= p_sas_nxt;
			p_ses_r <= p_ses_nxt;
			p_uas_r <= p_uas_nxt;
		end
	end

	// VT path counters, fed by the clamped parity count
	always_comb
	begin
		v_es_nxt = v_es_r;
		v_ses_nxt = v_ses_r;
		v_uas_nxt = v_uas_r;
		// At most two a superframe, so the live add stays a small step
		v_cv_nxt = v_cv_r + {{(CNT_W-2){1'b0}}, v_bip_now}; // RULE12
		if (sec_tick_i)
		begin
			if (v_es_sec)
				v_es_nxt = v_es_r + dvpm_pkg::CNT_ONE[CNT_W-1:0]; // RULE13
			if (v_ses_sec)
				v_ses_nxt = v_ses_r + dvpm_pkg::CNT_ONE[CNT_W-1:0]; // RULE14
			v_uas_nxt = v_uas_r + {{(CNT_W-5){1'b0}}, v_uas_add}; // RULE15
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			v_cv_r <= '0;
			v_es_r <= '0;
			v_ses_r <= '0;
			v_uas_r <= '0;
		end
		else
		begin
			v_cv_r <= v_cv_nxt;
			v_es_r <= v_es_nxt;
			v_ses_r <= v_ses_nxt;
			v_uas_r <= v_uas_nxt;
		end
	end

	assign path_alarm_seconds_o = p_ais_r;
	assign path_coding_violations_o = p_cv_r;
	assign path_errored_seconds_o = p_es_r;
	assign path_frame_alarm_seconds_o = p_sas_r;
	assign path_severe_seconds_o = p_ses_r;
	assign path_unavailable_seconds_o = p_uas_r;
	assign vt_coding_violations_o = v_cv_r;
	assign vt_errored_seconds_o = v_es_r;
	assign vt_severe_seconds_o = v_ses_r;
	assign vt_unavailable_seconds_o = v_uas_r;
	// Strobe trails the tick by one, when every counter has settled
	assign sec_done_o = done_r;
endmodule

// ### verification/dvpm_chk_monitor.sv
// Concurrent checks on the DS1/VT performance monitor ports.
// Assumes a bind onto dvpm_monitor; all checks live in one clock domain.
`timescale 1ns/1ps
module dvpm_chk
#(
	parameter int CNT_W = 32
)
(
	// Clock, reset and interval
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic sec_tick_i,
	input wire logic path_esf_i,
	// Anomalies and defects
	input wire logic crc_error_i,
	input wire logic framing_bit_error_i,
	input wire logic frame_change_i,
	input wire logic severe_framing_defect_i,
	input wire logic path_alarm_defect_i,
	input wire logic [1:0] vt_bip_count_i,
	input wire logic vt_bip_valid_i,
	input wire logic vt_alarm_defect_i,
	// Counters and strobe
	input wire logic [CNT_W-1:0] path_alarm_seconds_o,
	input wire logic [CNT_W-1:0] path_coding_violations_o,
	input wire logic [CNT_W-1:0] path_errored_seconds_o,
	input wire logic [CNT_W-1:0] path_frame_alarm_seconds_o,
	input wire logic [CNT_W-1:0] path_severe_seconds_o,
	input wire logic [CNT_W-1:0] vt_coding_violations_o,
	input wire logic [CNT_W-1:0] vt_errored_seconds_o,
	input wire logic [CNT_W-1:0] vt_severe_seconds_o,
	input wire logic sec_done_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	done_follows_a: assert property (sec_tick_i |=> sec_done_o)
		else $error("done strobe missing after tick");
	done_cause_a: assert property (sec_done_o |-> $past(sec_tick_i))
		else $error("done strobe without tick");
	cv_esf_a: assert property (path_esf_i && crc_error_i |=>
		path_coding_violations_o == $past(path_coding_violations_o) + 1)
		else $error("crc error not counted");
	cv_sf_a: assert property (!path_esf_i && framing_bit_error_i |=>
		path_coding_violations_o == $past(path_coding_violations_o) + 1)
		else $error("framing bit error not counted");
	alarm_sec_a: assert property (sec_tick_i && path_alarm_defect_i |=>
		path_alarm_seconds_o == $past(path_alarm_seconds_o) + 1)
		else $error("alarm second not counted");
	frame_alarm_a: assert property (sec_tick_i && severe_framing_defect_i |=>
		path_frame_alarm_seconds_o == $past(path_frame_alarm_seconds_o) + 1)
		else $error("frame alarm second not counted");
	path_ses_a: assert property (sec_tick_i && path_alarm_defect_i |=>
		path_severe_seconds_o == $past(path_severe_seconds_o) + 1)
		else $error("defect second not severe");
	path_es_a: assert property (sec_tick_i && frame_change_i |=>
		path_errored_seconds_o == $past(path_errored_seconds_o) + 1)
		else $error("frame change second not errored");
	vt_cv_a: assert property (vt_bip_valid_i && vt_bip_count_i == 2'h1 |=>
		vt_coding_violations_o == $past(vt_coding_violations_o) + 1)
		else $error("vt parity error not counted");
	vt_defect_a: assert property (sec_tick_i && vt_alarm_defect_i |=>
		vt_errored_seconds_o == $past(vt_errored_seconds_o) + 1 &&
		vt_severe_seconds_o == $past(vt_severe_seconds_o) + 1)
		else $error("vt defect second not counted");
endmodule
bind dvpm_monitor dvpm_chk #(.CNT_W(CNT_W)) i_dvpm_chk
(
	.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i),
	.sec_tick_i(sec_tick_i),
	.path_esf_i(path_esf_i),
	.crc_error_i(crc_error_i),
	.framing_bit_error_i(framing_bit_error_i),
	.frame_change_i(frame_change_i),
	.severe_framing_defect_i(severe_framing_defect_i),
	.path_alarm_defect_i(path_alarm_defect_i),
	.vt_bip_count_i(vt_bip_count_i),
	.vt_bip_valid_i(vt_bip_valid_i),
	.vt_alarm_defect_i(vt_alarm_defect_i),
	.path_alarm_seconds_o(path_alarm_seconds_o),
	.path_coding_violations_o(path_coding_violations_o),
	.path_errored_seconds_o(path_errored_seconds_o),
	.path_frame_alarm_seconds_o(path_frame_alarm_seconds_o),
	.path_severe_seconds_o(path_severe_seconds_o),
	.vt_coding_violations_o(vt_coding_violations_o),
	.vt_errored_seconds_o(vt_errored_seconds_o),
	.vt_severe_seconds_o(vt_severe_seconds_o),
	.sec_done_o(sec_done_o)
);

// ### verification/dvpm_far_end.sv
// Far-end path model: sends DS1 and VT anomaly pulses on request.
// Assumes the bench calls burst; outputs move only after falling edges.
`timescale 1ns/1ps
module dvpm_far_end
(
	// Clock
	input wire logic ref_clk_i,
	// Anomaly pulses
	output logic crc_o,
	output logic fbit_o,
	output logic chg_o,
	output logic [1:0] bip_o,
	output logic bip_v_o
);
	// Idle parity count is junk so a missing qualifier shows up
	initial
	begin
		{crc_o, fbit_o, chg_o, bip_o, bip_v_o} = 6'h06;
	end
	// Kind 0 crc, 1 framing bit, 2 frame change, 3.. parity count kind-3
	task automatic burst(input int kind, input int n);
		repeat (n)
		begin
			@(negedge ref_clk_i);
			crc_o = (kind == 0);
			fbit_o = (kind == 1);
			chg_o = (kind == 2);
			bip_v_o = (kind >= 3);
			bip_o = (kind >= 3) ? 2'(kind - 3) : 2'h3;
		end
		@(negedge ref_clk_i);
		{crc_o, fbit_o, chg_o, bip_o, bip_v_o} = 6'h06;
	endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the DS1/VT path performance monitor.
// Assumes the checker bind is compiled alongside.
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic tick = 1'b0;
	logic esf = 1'b1;
	logic sev = 1'b0;
	logic ais = 1'b0;
	logic [2:0] vd = 3'h0;
	logic crc, fbit, chg, bv, pu, vu, done;
	logic [1:0] bc;
	logic [31:0] c [10];
	logic [31:0] b [10];
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	dvpm_far_end i_dvpm_far_end (.ref_clk_i(ref_clk_i), .crc_o(crc), .fbit_o(fbit),
		.chg_o(chg), .bip_o(bc), .bip_v_o(bv));
	dvpm_monitor i_dvpm_monitor (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.sec_tick_i(tick), .path_esf_i(esf), .crc_error_i(crc),
		.framing_bit_error_i(fbit), .frame_change_i(chg), .severe_framing_defect_i(sev),
		.path_alarm_defect_i(ais), .vt_bip_count_i(bc), .vt_bip_valid_i(bv),
		.vt_alarm_defect_i(vd[2]), .vt_pointer_loss_defect_i(vd[1]),
		.lower_layer_defect_i(vd[0]), .path_alarm_seconds_o(c[0]),
		.path_coding_violations_o(c[1]), .path_errored_seconds_o(c[2]),
		.path_frame_alarm_seconds_o(c[3]), .path_severe_seconds_o(c[4]),
		.path_unavailable_seconds_o(c[5]), .path_unavailable_o(pu),
		.vt_coding_violations_o(c[6]), .vt_errored_seconds_o(c[7]),
		.vt_severe_seconds_o(c[8]), .vt_unavailable_seconds_o(c[9]),
		.vt_unavailable_o(vu), .sec_done_o(done));
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic wrap_up;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic sec(input int n);
		repeat (n)
		begin
			@(negedge ref_clk_i);
			tick = 1'b1;
			@(negedge ref_clk_i);
			tick = 1'b0;
			chk({31'h0, done}, 32'h1);
		end
	endtask
	task automatic t_esf;
		esf = 1'b1;
		b = c;
		i_dvpm_far_end.burst(0, 3);
		i_dvpm_far_end.burst(1, 2);
		sec(1);
		chk(c[1], b[1] + 32'h3);
		chk(c[2], b[2] + 32'h1);
		chk(c[4], b[4]);
		i_dvpm_far_end.burst(0, 319);
		sec(1);
		chk(c[4], b[4]);
		i_dvpm_far_end.burst(0, 320);
		sec(1);
		chk(c[4], b[4] + 32'h1);
		$display("t_esf done");
	endtask
	task automatic t_sf;
		esf = 1'b0;
		b = c;
		i_dvpm_far_end.burst(1, 3);
		i_dvpm_far_end.burst(0, 5);
		sec(1);
		chk(c[1], b[1] + 32'h3);
		chk(c[2], b[2] + 32'h1);
		chk(c[4], b[4]);
		i_dvpm_far_end.burst(1, 4);
		sec(1);
		chk(c[4], b[4] + 32'h1);
		b = c;
		i_dvpm_far_end.burst(2, 1);
		sec(1);
		chk(c[2], b[2] + 32'h1);
		chk(c[1], b[1]);
		// Frame change in the tick cycle still belongs to the closing second
		b = c;
		fork
			i_dvpm_far_end.burst(2, 1);
			sec(1);
		join
		chk(c[2], b[2] + 32'h1);
		$display("t_sf done");
	endtask
	task automatic t_def;
		b = c;
		sev = 1'b1;
		sec(1);
		sev = 1'b0;
		chk(c[3], b[3] + 32'h1);
		chk(c[0], b[0]);
		ais = 1'b1;
		sec(1);
		ais = 1'b0;
		chk(c[0], b[0] + 32'h1);
		chk(c[4], b[4] + 32'h2);
		chk(c[3], b[3] + 32'h2);
		b = c;
		sec(1);
		chk(c[2], b[2]);
		$display("t_def done");
	endtask
	task automatic t_vt;
		b = c;
		i_dvpm_far_end.burst(6, 1);
		i_dvpm_far_end.burst(5, 1);
		i_dvpm_far_end.burst(4, 1);
		sec(1);
		chk(c[6], b[6] + 32'h5);
		chk(c[7], b[7] + 32'h1);
		chk(c[8], b[8]);
		i_dvpm_far_end.burst(5, 299);
		i_dvpm_far_end.burst(4, 1);
		sec(1);
		chk(c[8], b[8]);
		i_dvpm_far_end.burst(5, 300);
		sec(1);
		chk(c[8], b[8] + 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			b = c;
			vd = 3'h4 >> i;
			sec(1);
			vd = 3'h0;
			chk(c[7], b[7] + 32'h1);
			chk(c[8], b[8] + 32'h1);
		end
		$display("t_vt done");
	endtask
	task automatic t_unav;
		// One clean second first, so severe runs left by earlier tests start over
		sec(1);
		b = c;
		ais = 1'b1;
		vd = 3'h4;
		sec(9);
		chk({31'h0, pu}, 32'h0);
		chk({31'h0, vu}, 32'h0);
		sec(1);
		chk({31'h0, pu}, 32'h1);
		chk({31'h0, vu}, 32'h1);
		chk(c[5], b[5] + 32'ha);
		chk(c[9], b[9] + 32'ha);
		ais = 1'b0;
		vd = 3'h0;
		b = c;
		sec(3);
		ais = 1'b1;
		vd = 3'h4;
		sec(1);
		// Short clean run inside the period is unavailable time as well
		chk(c[5], b[5] + 32'h4);
		chk(c[9], b[9] + 32'h4);
		ais = 1'b0;
		vd = 3'h0;
		b = c;
		sec(10);
		chk({30'h0, pu, vu}, 32'h0);
		chk(c[5], b[5]);
		chk(c[9], b[9]);
		$display("t_unav done");
	endtask
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		resetn_i = 1'b1;
		t_esf();
		t_sf();
		t_def();
		t_vt();
		t_unav();
		wrap_up();
	end
endmodule
